// ---- inc/alert_pkg.sv ----
// alert_pkg: register map, field layout, reset values and carrier types
// for the cell and auxiliary alert status block.
// assumes word-indexed registers reached at byte address index*4.
package alert_pkg;

  localparam int NUM_CELLS = 12;
  localparam int SAMP_W = 12;
  localparam int CHAN_W = 4;
  localparam int REG_W = 16;
  localparam int IDX_W = 6;
  localparam int IRQ_W = 3;

  // register indices; byte address is index times four
  localparam logic [IDX_W-1:0] IDX_MAIN_STATUS = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CELL_SUMMARY = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CELL_OV = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CELL_UV = 6'h05;
  localparam logic [IDX_W-1:0] IDX_OV_THR = 6'h08;
  localparam logic [IDX_W-1:0] IDX_UV_THR = 6'h09;
  localparam logic [IDX_W-1:0] IDX_OT_THR = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_UT_THR = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h0d;

  // main status fields
  localparam int STAT_AUX0_BIT = 0;
  localparam int STAT_AUX1_BIT = 1;

  // interrupt status fields
  localparam int IRQ_SCAN_BIT = 0;
  localparam int IRQ_CELL_BIT = 1;
  localparam int IRQ_AUX_BIT = 2;

  // sample channel codes: 0..11 cells, then the two auxiliary inputs
  localparam logic [CHAN_W-1:0] CH_AUX0 = 4'hc;
  localparam logic [CHAN_W-1:0] CH_AUX1 = 4'hd;

  // reset values: thresholds chosen so that nothing trips after reset
  localparam logic [SAMP_W-1:0] OV_THR_RST = 12'hfff;
  localparam logic [SAMP_W-1:0] UV_THR_RST = 12'h000;
  localparam logic [SAMP_W-1:0] OT_THR_RST = 12'h000;
  localparam logic [SAMP_W-1:0] UT_THR_RST = 12'hfff;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [SAMP_W-1:0] data;
  } samp_s;

endpackage

// ---- core/thr_cmp.sv ----
// thr_cmp: compares one measured value against an upper and a lower limit.
// assumes value and limits are unsigned codes of the same width.
`timescale 1ns/1ps
module thr_cmp #(
  parameter int W = 12
) (
  input wire logic [W-1:0] value_in,
  input wire logic [W-1:0] hi_thr_in,
  input wire logic [W-1:0] lo_thr_in,
  output logic above_out,
  output logic below_out
);

  assign above_out = value_in > hi_thr_in;
  assign below_out = value_in < lo_thr_in;

endmodule

// ---- core/cell_aux_alert_status.sv ----
// cell_aux_alert_status: per-cell and auxiliary alert flags with an
// Avalon-MM register slave and a maskable interrupt.
// assumes samples and scan-end pulses come from logic on mclk_in.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module cell_aux_alert_status
  import alert_pkg::*;
#(
  parameter int CELLS = NUM_CELLS
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic samp_valid_in,
  input wire samp_s samp_in,
  input wire logic scan_done_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out
);

  logic [SAMP_W-1:0] ov_thr_r;
  logic [SAMP_W-1:0] uv_thr_r;
  logic [SAMP_W-1:0] ot_thr_r;
  logic [SAMP_W-1:0] ut_thr_r;
  logic [CELLS-1:0] ov_flag_r;
  logic [CELLS-1:0] uv_flag_r;
  logic [1:0] aux_flag_r;
  logic [CELLS-1:0] ov_sh_r;
  logic [CELLS-1:0] uv_sh_r;
  logic [1:0] aux_sh_r;
  logic [CELLS-1:0] ov_sh_nxt;
  logic [CELLS-1:0] uv_sh_nxt;
  logic [1:0] aux_sh_nxt;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_evt;
  logic rd_ready_r;
  logic [31:0] rd_val;
  logic [IDX_W-1:0] idx;
  logic wr_go;
  logic cell_over;
  logic cell_under;
  logic aux_cold;
  logic aux_hot;
  logic aux_fault;
  logic samp_is_cell;

  assign idx = avs_address_in[7:2];
  assign wr_go = avs_write_in;
  assign samp_is_cell = samp_valid_in && (samp_in.chan < CHAN_W'(CELLS));

  thr_cmp #(.W(SAMP_W)) u_cell_cmp (
    .value_in(samp_in.data),
    .hi_thr_in(ov_thr_r),
    .lo_thr_in(uv_thr_r),
    .above_out(cell_over),
    .below_out(cell_under)
  );

  // thermistor: hot reads low, cold reads high
  thr_cmp #(.W(SAMP_W)) u_aux_cmp (
    .value_in(samp_in.data),
    .hi_thr_in(ut_thr_r),
    .lo_thr_in(ot_thr_r),
    .above_out(aux_cold),
    .below_out(aux_hot)
  );

  assign aux_fault = aux_cold | aux_hot;

  // threshold registers, software writable
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ov_thr_r <= OV_THR_RST;
      uv_thr_r <= UV_THR_RST;
      ot_thr_r <= OT_THR_RST;
      ut_thr_r <= UT_THR_RST;
    end else if (wr_go) begin
      case (idx)
        IDX_OV_THR: begin
          if (avs_byteenable_in[0]) ov_thr_r[7:0] <= avs_writedata_in[7:0];
          if (avs_byteenable_in[1]) ov_thr_r[11:8] <= avs_writedata_in[11:8];
        end
        IDX_UV_THR: begin
          if (avs_byteenable_in[0]) uv_thr_r[7:0] <= avs_writedata_in[7:0];
          if (avs_byteenable_in[1]) uv_thr_r[11:8] <= avs_writedata_in[11:8];
        end
        IDX_OT_THR: begin
          if (avs_byteenable_in[0]) ot_thr_r[7:0] <= avs_writedata_in[7:0];
          if (avs_byteenable_in[1]) ot_thr_r[11:8] <= avs_writedata_in[11:8];
        end
        IDX_UT_THR: begin
          if (avs_byteenable_in[0]) ut_thr_r[7:0] <= avs_writedata_in[7:0];
          if (avs_byteenable_in[1]) ut_thr_r[11:8] <= avs_writedata_in[11:8];
        end
        default: begin
        end
      endcase
    end
  end

  // scan shadow: latest result per channel, including this cycle's sample
  always_comb begin
    ov_sh_nxt = ov_sh_r;
    uv_sh_nxt = uv_sh_r;
    aux_sh_nxt = aux_sh_r;
    if (samp_is_cell) begin
      ov_sh_nxt[samp_in.chan] = cell_over;
      uv_sh_nxt[samp_in.chan] = cell_under;
    end
    if (samp_valid_in && samp_in.chan == CH_AUX0) begin
      aux_sh_nxt[0] = aux_fault;
    end
    if (samp_valid_in && samp_in.chan == CH_AUX1) begin
      aux_sh_nxt[1] = aux_fault;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ov_sh_r <= '0;
      uv_sh_r <= '0;
      aux_sh_r <= '0;
    end else begin
      ov_sh_r <= ov_sh_nxt;
      uv_sh_r <= uv_sh_nxt;
      aux_sh_r <= aux_sh_nxt;
    end
  end

  // visible flags change only at scan end; a clean result clears them
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ov_flag_r <= '0;
      uv_flag_r <= '0;
      aux_flag_r <= '0;
    end else if (scan_done_in) begin
      ov_flag_r <= ov_sh_nxt;
      uv_flag_r <= uv_sh_nxt;
      aux_flag_r <= aux_sh_nxt;
    end
  end

  // interrupt events: scan end, newly raised cell alert, newly raised aux alert
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_SCAN_BIT] = scan_done_in;
    irq_evt[IRQ_CELL_BIT] = scan_done_in && |((ov_sh_nxt | uv_sh_nxt) & ~(ov_flag_r | uv_flag_r));
    irq_evt[IRQ_AUX_BIT] = scan_done_in && |(aux_sh_nxt & ~aux_flag_r);
  end

  // write one clears; a new event in the same cycle wins
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= '0;
    end else if (wr_go && idx == IDX_IRQ_STATUS && avs_byteenable_in[0]) begin
      irq_stat_r <= (irq_stat_r & ~avs_writedata_in[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_go && idx == IDX_IRQ_MASK && avs_byteenable_in[0]) begin
      irq_mask_r <= avs_writedata_in[IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // read mux; unused bits and unmapped addresses read zero
  always_comb begin
    rd_val = '0;
    case (idx)
      IDX_MAIN_STATUS: rd_val[1:0] = aux_flag_r;
      IDX_CELL_SUMMARY: rd_val[CELLS-1:0] = ov_flag_r | uv_flag_r;
      IDX_CELL_OV: rd_val[CELLS-1:0] = ov_flag_r;
      IDX_CELL_UV: rd_val[CELLS-1:0] = uv_flag_r;
      IDX_OV_THR: rd_val[SAMP_W-1:0] = ov_thr_r;
      IDX_UV_THR: rd_val[SAMP_W-1:0] = uv_thr_r;
      IDX_OT_THR: rd_val[SAMP_W-1:0] = ot_thr_r;
      IDX_UT_THR: rd_val[SAMP_W-1:0] = ut_thr_r;
      IDX_IRQ_STATUS: rd_val[IRQ_W-1:0] = irq_stat_r;
      IDX_IRQ_MASK: rd_val[IRQ_W-1:0] = irq_mask_r;
      default: rd_val = '0;
    endcase
  end

  // reads take one wait cycle; writes complete at once
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_ready_r <= 1'b0;
      avs_readdata_out <= '0;
    end else begin
      rd_ready_r <= avs_read_in && !rd_ready_r;
      if (avs_read_in && !rd_ready_r) begin
        avs_readdata_out <= rd_val;
      end
    end
  end

  assign avs_waitrequest_out = avs_read_in && !rd_ready_r;

  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  reserved_read_zero_a: assert property (
    (avs_read_in && !avs_waitrequest_out) |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  status_reserved_a: assert property (
    (avs_read_in && !avs_waitrequest_out && idx == IDX_MAIN_STATUS) |-> avs_readdata_out[15:2] == 14'h0000)
    else $error("reserved status bits not zero");

  aux1_fault_set_a: assert property (
    (samp_valid_in && samp_in.chan == CH_AUX1) |=> aux_sh_r[1] == $past(aux_fault))
    else $error("aux1 result does not follow its measurement");

  aux0_hot_set_a: assert property (
    (samp_valid_in && samp_in.chan == CH_AUX0 && samp_in.data < ot_thr_r) |=> aux_sh_r[0])
    else $error("aux0 over-temperature not recorded");

  aux_clean_clear_a: assert property (
    (samp_valid_in && samp_in.chan == CH_AUX0 && samp_in.data >= ot_thr_r
     && samp_in.data <= ut_thr_r) |=> !aux_sh_r[0])
    else $error("aux0 result not cleared after clean measurement");

  aux_cold_cmp_a: assert property (
    (samp_valid_in && samp_in.data > ut_thr_r) |-> aux_fault)
    else $error("under-temperature compare wrong");

  status_write_keep_a: assert property (
    (avs_write_in && idx == IDX_MAIN_STATUS && !scan_done_in) |=> $stable(aux_flag_r))
    else $error("status write changed aux flags");

  summary_or_a: assert property (
    (avs_read_in && !avs_waitrequest_out && $past(idx) == IDX_CELL_SUMMARY)
    |-> avs_readdata_out[CELLS-1:0] == $past(ov_flag_r | uv_flag_r))
    else $error("cell summary is not ov or uv");

  cell_ov_set_a: assert property (
    (samp_is_cell && samp_in.data > ov_thr_r) |=> ov_sh_r[$past(samp_in.chan)])
    else $error("cell overvoltage not recorded");

  cell_uv_clear_a: assert property (
    (samp_is_cell && samp_in.data >= uv_thr_r) |=> !uv_sh_r[$past(samp_in.chan)])
    else $error("cell undervoltage not cleared");

  cell_uv_set_a: assert property (
    (samp_is_cell && samp_in.data < uv_thr_r) |=> uv_sh_r[$past(samp_in.chan)])
    else $error("cell undervoltage not recorded");

  flags_hold_a: assert property (
    !scan_done_in |=> $stable(ov_flag_r) && $stable(uv_flag_r) && $stable(aux_flag_r))
    else $error("flags changed outside scan end");

  read_wait_one_a: assert property (
    (avs_read_in && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("read waited more than one cycle");

  cov_cell_alert_c: cover property (scan_done_in ##1 |ov_flag_r);
  cov_aux_alert_c: cover property (scan_done_in ##1 |aux_flag_r);
  cov_irq_c: cover property (irq_out);

endmodule

// ---- bench/cell_aux_alert_status_tb_top.sv ----
// cell_aux_alert_status_tb_top: self-checking bench with a reference model.
// assumes alert_pkg and the design are compiled first.
`timescale 1ns/1ps
module cell_aux_alert_status_tb_top;
  import alert_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic samp_valid_in = 1'b0;
  samp_s samp_in = '0;
  logic scan_done_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic irq_out;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h31be;
  logic [11:0] thr [4] = '{12'h800, 12'h200, 12'h300, 12'hc00};
  logic [11:0] ov_sh = 12'h0, uv_sh = 12'h0, ov_m = 12'h0, uv_m = 12'h0;
  logic [1:0] aux_sh = 2'h0, aux_m = 2'h0;
  logic [2:0] st_m = 3'h0, mask_m = 3'h0;

  cell_aux_alert_status DUT (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .samp_valid_in(samp_valid_in), .samp_in(samp_in),
    .scan_done_in(scan_done_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out)
  );

  always #25 mclk_in = ~mclk_in;

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus transfer; held until waitrequest is seen low at a rising edge
  task automatic bus(input bit we, input logic [5:0] idx, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] d);
    avs_address_in <= {idx, 2'b00};
    avs_writedata_in <= wd;
    avs_byteenable_in <= be;
    avs_read_in <= !we;
    avs_write_in <= we;
    // waitrequest and read data both taken at the rising edge
    do @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0);
    d = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    // one idle edge so no strobe is driven twice in a time step
    @(posedge mclk_in);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] d;
    bus(1'b1, idx, wd, be, d);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, 4'hf, d);
    check(d, exp);
  endtask

  task automatic irq_chk();
    @(negedge mclk_in);
    check({31'h0, irq_out}, {31'h0, |(st_m & mask_m)});
    @(posedge mclk_in);
  endtask

  // one scan over channels 0..15; 14 and 15 are not real channels
  task automatic scan(input bit mid_chk);
    logic [31:0] r;
    logic [11:0] d;
    for (int c = 0; c < 16; c++) begin
      rng = xs(rng);
      r = rng;
      if (c < 14 && r[15]) continue;
      d = r[14] ? r[11:0] : thr[r[13:12]] + {10'h0, r[1:0]} - 12'h1;
      if (mid_chk && c == 8) begin
        samp_valid_in <= 1'b0;
        rd_chk(IDX_CELL_OV, {20'h0, ov_m});
      end
      samp_valid_in <= 1'b1;
      samp_in <= '{chan: c[3:0], data: d};
      scan_done_in <= (c == 15);
      @(posedge mclk_in);
      if (c < 12) begin
        ov_sh[c] = d > thr[0];
        uv_sh[c] = d < thr[1];
      end else if (c < 14) begin
        aux_sh[c-12] = d < thr[2] || d > thr[3];
      end
    end
    samp_valid_in <= 1'b0;
    scan_done_in <= 1'b0;
    st_m[IRQ_SCAN_BIT] = 1'b1;
    if (((ov_sh | uv_sh) & ~(ov_m | uv_m)) != 12'h0) st_m[IRQ_CELL_BIT] = 1'b1;
    if ((aux_sh & ~aux_m) != 2'h0) st_m[IRQ_AUX_BIT] = 1'b1;
    ov_m = ov_sh;
    uv_m = uv_sh;
    aux_m = aux_sh;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    rd_chk(IDX_OV_THR, {20'h0, OV_THR_RST});
    rd_chk(IDX_UV_THR, {20'h0, UV_THR_RST});
    rd_chk(IDX_OT_THR, {20'h0, OT_THR_RST});
    rd_chk(IDX_UT_THR, {20'h0, UT_THR_RST});
    rd_chk(IDX_IRQ_MASK, {29'h0, IRQ_MASK_RST});
    rd_chk(IDX_MAIN_STATUS, 32'h0);
    // lane 0 only: bits 11:8 keep their reset ones
    wr(IDX_OV_THR, 32'h0, 4'h1);
    rd_chk(IDX_OV_THR, 32'hf00);
    for (int i = 0; i < 4; i++) wr(IDX_OV_THR + i[5:0], {20'h0, thr[i]}, 4'hf);
    wr(6'h3f, 32'hffff_ffff, 4'hf);
    rd_chk(6'h3f, 32'h0);
    for (int k = 0; k < 40; k++) begin
      scan(k[0]);
      for (int i = 2; i < 6; i++) wr(i[5:0], 32'hffff_ffff, 4'hf);
      rd_chk(IDX_MAIN_STATUS, {30'h0, aux_m});
      rd_chk(IDX_CELL_SUMMARY, {20'h0, ov_m | uv_m});
      rd_chk(IDX_CELL_OV, {20'h0, ov_m});
      rd_chk(IDX_CELL_UV, {20'h0, uv_m});
      rd_chk(IDX_IRQ_STATUS, {29'h0, st_m});
      irq_chk();
      rng = xs(rng);
      mask_m = rng[2:0];
      wr(IDX_IRQ_MASK, {29'h0, mask_m}, 4'hf);
      irq_chk();
      wr(IDX_IRQ_STATUS, {29'h0, rng[5:3]}, 4'hf);
      st_m = st_m & ~rng[5:3];
      irq_chk();
    end
    // second reset after the scan loop: flags and interrupt state return to reset
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    rd_chk(IDX_CELL_SUMMARY, 32'h0);
    rd_chk(IDX_MAIN_STATUS, 32'h0);
    rd_chk(IDX_IRQ_STATUS, 32'h0);
    rd_chk(IDX_OT_THR, {20'h0, OT_THR_RST});
    end_sim();
  end
endmodule
